/* File: prh_top.sv */
// pwm rerouting and port h pin logic with axi4-lite register access
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`default_nettype none
module prh_top
  import prh_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write address
  input  wire logic [PRH_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [PRH_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pwm channel outputs and enables
  input  wire logic [7:0]            pwm_out,
  input  wire logic [7:0]            pwm_en,
  // rerouted pwm drive on ports p, s and v
  output logic      [7:0]            port_p_pwm_out,
  output logic      [7:0]            port_p_pwm_en,
  output logic      [7:0]            port_s_pwm_out,
  output logic      [7:0]            port_s_pwm_en,
  output logic      [3:0]            port_v_pwm_out,
  output logic      [3:0]            port_v_pwm_en,
  // port h pins
  input  wire logic [7:0]            port_h_pin_in,
  output logic      [7:0]            port_h_pin_out,
  output logic      [7:0]            port_h_pin_oe,
  output logic      [7:0]            port_h_sync_in,
  // lcd segment enables per port h pin
  input  wire logic [7:0]            lcd_seg_en,
  // iic function on port h
  input  wire logic                  iic_en,
  input  wire logic                  iic_sda_out,
  input  wire logic                  iic_sda_oe,
  input  wire logic                  iic_scl_out,
  input  wire logic                  iic_scl_oe,
  // spi function on port h
  input  wire logic                  spi_en,
  input  wire logic                  spi_ss_out,
  input  wire logic                  spi_ss_oe,
  input  wire logic                  spi_sck_out,
  input  wire logic                  spi_sck_oe,
  input  wire logic                  spi_mosi_out,
  input  wire logic                  spi_mosi_oe,
  input  wire logic                  spi_miso_out,
  input  wire logic                  spi_miso_oe,
  // bus clock output function
  input  wire logic                  bus_clock_output_en,
  input  wire logic                  bus_clock_output
);
  // software registers
  logic [7:0]            pwm_route_high_reg;
  logic [7:0]            pwm_route_low_reg;
  logic [7:0]            port_h_data_reg;
  logic [7:0]            port_h_direction_reg;
  // pin synchroniser stages
  logic [7:0]            sync1_reg;
  logic [7:0]            sync2_reg;
  logic [7:0]            sync3_reg;
  logic [7:0]            pin_state_reg;
  // write channel state
  logic                  aw_held_reg;
  logic                  w_held_reg;
  logic [PRH_ADDR_W-1:0] aw_addr_reg;
  logic [31:0]           w_data_reg;
  logic [3:0]            w_strb_reg;
  logic                  do_write;
  logic                  wr_hit;
  // pin mux results
  logic [7:0]            mux_out;
  logic [7:0]            mux_oe;
  // pwm routing results
  logic [7:0]            p_out_next;
  logic [7:0]            p_en_next;
  logic [7:0]            s_out_next;
  logic [7:0]            s_en_next;
  logic [3:0]            v_out_next;
  logic [3:0]            v_en_next;
  logic [1:0]            ch7_sel;
  logic [1:0]            ch6_sel;
  // read decode
  logic [7:0]            rd_byte;
  logic                  rd_hit;

  // write address channel: hold one address until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_reg   <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_reg   <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_reg   <= 1'b0;
    end else if (!aw_held_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_reg   <= 1'b0;
    end else if (!w_held_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // commit once both halves are held and no response is pending
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_hit   = (aw_addr_reg == PRH_OFF_ROUTE_HIGH) ||
                    (aw_addr_reg == PRH_OFF_ROUTE_LOW)  ||
                    (aw_addr_reg == PRH_OFF_H_DATA)     ||
                    (aw_addr_reg == PRH_OFF_H_INPUT)    ||
                    (aw_addr_reg == PRH_OFF_H_DIR);

  // write response: slverr on unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PRH_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? PRH_RESP_OKAY : PRH_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes through byte lane 0; no mode restrictions apply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_route_high_reg   <= PRH_RST_ROUTE_HIGH;
      pwm_route_low_reg    <= PRH_RST_ROUTE_LOW;
      port_h_data_reg      <= PRH_RST_H_DATA;
      port_h_direction_reg <= PRH_RST_H_DIR;
    end else if (do_write && w_strb_reg[0]) begin
      case (aw_addr_reg)
        PRH_OFF_ROUTE_HIGH: begin
          pwm_route_high_reg <= {6'h00, w_data_reg[1:0]};
        end
        PRH_OFF_ROUTE_LOW: begin
          pwm_route_low_reg <= w_data_reg[7:0];
        end
        PRH_OFF_H_DATA: begin
          port_h_data_reg <= w_data_reg[7:0];
        end
        PRH_OFF_H_DIR: begin
          port_h_direction_reg <= w_data_reg[7:0];
        end
        default: begin
          // input register and unmapped: no state changes
        end
      endcase
    end
  end

  // pin synchroniser: three stages, accept when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      sync3_reg     <= '0;
      pin_state_reg <= '0;
    end else begin
      sync1_reg <= port_h_pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int b = 0; b < 8; b++) begin
        if (sync2_reg[b] == sync3_reg[b]) begin
          pin_state_reg[b] <= sync3_reg[b];
        end
      end
    end
  end

  // read byte selection
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      PRH_OFF_ROUTE_HIGH: rd_byte = pwm_route_high_reg;
      PRH_OFF_ROUTE_LOW:  rd_byte = pwm_route_low_reg;
      PRH_OFF_H_DATA: begin
        rd_byte = (port_h_direction_reg & port_h_data_reg) |
                  (~port_h_direction_reg & pin_state_reg);
      end
      PRH_OFF_H_INPUT:    rd_byte = pin_state_reg;
      PRH_OFF_H_DIR:      rd_byte = port_h_direction_reg;
      default:            rd_hit  = 1'b0;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= PRH_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? PRH_RESP_OKAY : PRH_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pwm rerouting decode
  assign ch7_sel = pwm_route_high_reg[PRH_CH7_LSB +: 2];
  assign ch6_sel = pwm_route_low_reg[PRH_CH6_LSB +: 2];

  always_comb begin
    p_out_next = pwm_out;
    p_en_next  = pwm_en;
    s_out_next = 8'h00;
    s_en_next  = 8'h00;
    v_out_next = 4'h0;
    v_en_next  = 4'h0;
    // channel 7: 01 port s bit1, 10 port v bit3, else port p
    if (ch7_sel == PRH_SEL_S) begin
      s_out_next[1] = pwm_out[7];
      s_en_next[1]  = pwm_en[7];
    end else if (ch7_sel == PRH_SEL_V) begin
      v_out_next[3] = pwm_out[7];
      v_en_next[3]  = pwm_en[7];
    end
    if (ch7_sel == PRH_SEL_S || ch7_sel == PRH_SEL_V) begin
      p_out_next[7] = 1'b0;
      p_en_next[7]  = 1'b0;
    end
    // channel 6: 01 port s bit0, 10 port v bit2, else port p
    if (ch6_sel == PRH_SEL_S) begin
      s_out_next[0] = pwm_out[6];
      s_en_next[0]  = pwm_en[6];
    end else if (ch6_sel == PRH_SEL_V) begin
      v_out_next[2] = pwm_out[6];
      v_en_next[2]  = pwm_en[6];
    end
    if (ch6_sel == PRH_SEL_S || ch6_sel == PRH_SEL_V) begin
      p_out_next[6] = 1'b0;
      p_en_next[6]  = 1'b0;
    end
    // channels 5 and 4 to port v bits 1 and 0
    for (int c = 4; c < 6; c++) begin
      if (pwm_route_low_reg[c]) begin
        v_out_next[c-4] = pwm_out[c];
        v_en_next[c-4]  = pwm_en[c];
        p_out_next[c]   = 1'b0;
        p_en_next[c]    = 1'b0;
      end
    end
    // channels 3 to 0 to port s bits 7 to 4
    for (int c = 0; c < 4; c++) begin
      if (pwm_route_low_reg[c]) begin
        s_out_next[c+4] = pwm_out[c];
        s_en_next[c+4]  = pwm_en[c];
        p_out_next[c]   = 1'b0;
        p_en_next[c]    = 1'b0;
      end
    end
  end

  // port h function priority
  prh_pin_mux prh_pin_mux_inst (
    .gpio_out (port_h_data_reg),
    .gpio_dir (port_h_direction_reg),
    .lcd_en   (lcd_seg_en),
    .iic_en   (iic_en),
    .sda_out  (iic_sda_out),
    .sda_oe   (iic_sda_oe),
    .scl_out  (iic_scl_out),
    .scl_oe   (iic_scl_oe),
    .spi_en   (spi_en),
    .ss_out   (spi_ss_out),
    .ss_oe    (spi_ss_oe),
    .sck_out  (spi_sck_out),
    .sck_oe   (spi_sck_oe),
    .mosi_out (spi_mosi_out),
    .mosi_oe  (spi_mosi_oe),
    .miso_out (spi_miso_out),
    .miso_oe  (spi_miso_oe),
    .bco_en   (bus_clock_output_en),
    .bco_out  (bus_clock_output),
    .pin_out  (mux_out),
    .pin_oe   (mux_oe)
  );

  // registered pin-side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_p_pwm_out <= '0;
      port_p_pwm_en  <= '0;
      port_s_pwm_out <= '0;
      port_s_pwm_en  <= '0;
      port_v_pwm_out <= '0;
      port_v_pwm_en  <= '0;
      port_h_pin_out <= '0;
      port_h_pin_oe  <= '0;
      port_h_sync_in <= '0;
    end else begin
      port_p_pwm_out <= p_out_next;
      port_p_pwm_en  <= p_en_next;
      port_s_pwm_out <= s_out_next;
      port_s_pwm_en  <= s_en_next;
      port_v_pwm_out <= v_out_next;
      port_v_pwm_en  <= v_en_next;
      port_h_pin_out <= mux_out;
      port_h_pin_oe  <= mux_oe;
      port_h_sync_in <= pin_state_reg;
    end
  end
endmodule
`default_nettype wire

/* File: prh_pkg.sv */
// package with register map, field positions and reset values for prh
`default_nettype none
package prh_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] PRH_OFF_ROUTE_HIGH = 8'h00;
  localparam logic [7:0] PRH_OFF_ROUTE_LOW  = 8'h04;
  localparam logic [7:0] PRH_OFF_H_DATA     = 8'h08;
  localparam logic [7:0] PRH_OFF_H_INPUT    = 8'h0C;
  localparam logic [7:0] PRH_OFF_H_DIR      = 8'h10;
  localparam int         PRH_ADDR_W         = 8;
  // reset values
  localparam logic [7:0] PRH_RST_ROUTE_HIGH = 8'h00;
  localparam logic [7:0] PRH_RST_ROUTE_LOW  = 8'h00;
  localparam logic [7:0] PRH_RST_H_DATA     = 8'h00;
  localparam logic [7:0] PRH_RST_H_DIR      = 8'h00;
  // routing field positions
  localparam int         PRH_CH7_LSB        = 0;  // high reg bits 1:0
  localparam int         PRH_CH6_LSB        = 6;  // low reg bits 7:6
  // two-bit routing field codes
  localparam logic [1:0] PRH_SEL_S          = 2'h1;
  localparam logic [1:0] PRH_SEL_V          = 2'h2;
  // axi response codes
  localparam logic [1:0] PRH_RESP_OKAY      = 2'h0;
  localparam logic [1:0] PRH_RESP_SLVERR    = 2'h2;
endpackage
`default_nettype wire

/* File: prh_pin_mux.sv */
// port h per-pin function priority selector, purely combinational
`default_nettype none
module prh_pin_mux (
  // general purpose data and direction
  input  wire logic [7:0] gpio_out,
  input  wire logic [7:0] gpio_dir,
  // lcd segment function
  input  wire logic [7:0] lcd_en,
  // iic function
  input  wire logic       iic_en,
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  input  wire logic       scl_out,
  input  wire logic       scl_oe,
  // spi function
  input  wire logic       spi_en,
  input  wire logic       ss_out,
  input  wire logic       ss_oe,
  input  wire logic       sck_out,
  input  wire logic       sck_oe,
  input  wire logic       mosi_out,
  input  wire logic       mosi_oe,
  input  wire logic       miso_out,
  input  wire logic       miso_oe,
  // bus clock output function
  input  wire logic       bco_en,
  input  wire logic       bco_out,
  // resolved pin drive
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe
);
  // pins 7..4: lcd over gpio; lcd disables the digital buffer
  genvar i;
  generate
    for (i = 4; i < 8; i++) begin : g_hi
      assign pin_out[i] = lcd_en[i] ? 1'b0 : gpio_out[i];
      assign pin_oe[i]  = lcd_en[i] ? 1'b0 : gpio_dir[i];
    end
  endgenerate

  // pins 3..0: fixed priority chains
  always_comb begin
    pin_out[3:0] = gpio_out[3:0];
    pin_oe[3:0]  = gpio_dir[3:0];
    // pin 3: lcd, iic sda, spi ss, gpio
    if (lcd_en[3]) begin
      pin_out[3] = 1'b0;
      pin_oe[3]  = 1'b0;
    end else if (iic_en) begin
      pin_out[3] = sda_out;
      pin_oe[3]  = sda_oe;
    end else if (spi_en) begin
      pin_out[3] = ss_out;
      pin_oe[3]  = ss_oe;
    end
    // pin 2: lcd, spi sck, bus clock output, gpio
    if (lcd_en[2]) begin
      pin_out[2] = 1'b0;
      pin_oe[2]  = 1'b0;
    end else if (spi_en) begin
      pin_out[2] = sck_out;
      pin_oe[2]  = sck_oe;
    end else if (bco_en) begin
      pin_out[2] = bco_out;
      pin_oe[2]  = 1'b1;
    end
    // pin 1: lcd, spi mosi, gpio
    if (lcd_en[1]) begin
      pin_out[1] = 1'b0;
      pin_oe[1]  = 1'b0;
    end else if (spi_en) begin
      pin_out[1] = mosi_out;
      pin_oe[1]  = mosi_oe;
    end
    // pin 0: lcd, iic scl, spi miso, gpio
    if (lcd_en[0]) begin
      pin_out[0] = 1'b0;
      pin_oe[0]  = 1'b0;
    end else if (iic_en) begin
      pin_out[0] = scl_out;
      pin_oe[0]  = scl_oe;
    end else if (spi_en) begin
      pin_out[0] = miso_out;
      pin_oe[0]  = miso_oe;
    end
  end
endmodule
`default_nettype wire

/* File: prh_top_asserts.sv */
// bound checker for the prh register bus and pin outputs
`default_nettype none
module prh_top_asserts (
  // clock, reset and register bus
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pwm routing
  input wire logic [7:0]  pwm_en,
  input wire logic [7:0]  port_p_pwm_en,
  input wire logic [7:0]  port_s_pwm_en,
  input wire logic [3:0]  port_v_pwm_en,
  // port h functions
  input wire logic [7:0]  port_h_pin_out,
  input wire logic [7:0]  port_h_pin_oe,
  input wire logic [7:0]  lcd_seg_en,
  input wire logic        iic_en,
  input wire logic        iic_sda_oe,
  input wire logic        spi_en,
  input wire logic        spi_sck_oe,
  input wire logic        bus_clock_output_en,
  input wire logic        bus_clock_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic live_reg;
  // high once the previous edge was already out of reset
  always_ff @(posedge aclk) begin
    live_reg <= aresetn;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // write address and data taken together
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  wr_resp_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  resp_hold_a: assert property (b_wait
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  route_one_a: assert property (live_reg |-> $countones({
    port_p_pwm_en[7], port_s_pwm_en[1], port_v_pwm_en[3]})
    == $past(pwm_en[7]))
    else $error("pwm7 not on exactly one pin");
  lcd_off_a: assert property (live_reg |->
    ($past(lcd_seg_en) & (port_h_pin_oe | port_h_pin_out)) == 8'h00)
    else $error("lcd pin still driven");
  sda_first_a: assert property (live_reg && $past(iic_en)
    && !$past(lcd_seg_en[3]) |-> port_h_pin_oe[3] == $past(iic_sda_oe))
    else $error("pin3 not owned by iic");
  sck_first_a: assert property (live_reg && $past(spi_en)
    && !$past(lcd_seg_en[2]) |-> port_h_pin_oe[2] == $past(spi_sck_oe))
    else $error("pin2 not owned by spi");
  clk_out_a: assert property (live_reg && !$past(spi_en)
    && $past(bus_clock_output_en) && !$past(lcd_seg_en[2])
    |-> port_h_pin_oe[2] && port_h_pin_out[2] == $past(bus_clock_output))
    else $error("pin2 not driving bus clock");
endmodule
bind prh_top prh_top_asserts prh_top_asserts_inst (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .pwm_en, .port_p_pwm_en, .port_s_pwm_en,
  .port_v_pwm_en, .port_h_pin_out, .port_h_pin_oe, .lcd_seg_en, .iic_en,
  .iic_sda_oe, .spi_en, .spi_sck_oe, .bus_clock_output_en, .bus_clock_output
);
`default_nettype wire

/* File: prh_pin_model.sv */
// pad model for port h: block drive or board level per pin
`default_nettype none
module prh_pin_model (
  // block drive
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // board level on undriven pads
  input  wire logic [7:0] board_lvl,
  // resolved pad level
  output logic      [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pad follows the block, an undriven one the board
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule
`default_nettype wire

/* File: test_pwm_reroute_and_port_h_io.sv */
// self-checking bench for pwm routing and port h pins
`default_nettype none
module test_pwm_reroute_and_port_h_io import prh_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        iic_en, spi_en, bus_clock_output_en, bus_clock_output;
  logic        iic_sda_out, iic_sda_oe, iic_scl_out, iic_scl_oe;
  logic        spi_ss_out, spi_ss_oe, spi_sck_out, spi_sck_oe;
  logic        spi_mosi_out, spi_mosi_oe, spi_miso_out, spi_miso_oe;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [12:0] drv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pwm_out, pwm_en, lcd_seg_en;
  logic [7:0]  port_p_pwm_out, port_p_pwm_en, port_s_pwm_out, port_s_pwm_en;
  logic [7:0]  port_h_pin_in, port_h_pin_out, port_h_pin_oe, port_h_sync_in;
  logic [7:0]  board_lvl;
  logic [3:0]  s_axi_wstrb, port_v_pwm_out, port_v_pwm_en;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          err_count, n_compared;
  // function drive levels from one vector
  assign {bus_clock_output, spi_miso_out, spi_miso_oe, spi_mosi_out,
    spi_mosi_oe, spi_sck_out, spi_sck_oe, spi_ss_out, spi_ss_oe,
    iic_scl_out, iic_scl_oe, iic_sda_out, iic_sda_oe} = drv;
  prh_top prh_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pwm_out, .pwm_en, .port_p_pwm_out,
    .port_p_pwm_en, .port_s_pwm_out, .port_s_pwm_en, .port_v_pwm_out,
    .port_v_pwm_en, .port_h_pin_in, .port_h_pin_out, .port_h_pin_oe,
    .port_h_sync_in, .lcd_seg_en, .iic_en, .iic_sda_out, .iic_sda_oe,
    .iic_scl_out, .iic_scl_oe, .spi_en, .spi_ss_out, .spi_ss_oe,
    .spi_sck_out, .spi_sck_oe, .spi_mosi_out, .spi_mosi_oe, .spi_miso_out,
    .spi_miso_oe, .bus_clock_output_en, .bus_clock_output);
  prh_pin_model prh_pin_model_inst (.pin_out(port_h_pin_out),
    .pin_oe(port_h_pin_oe), .board_lvl, .pin_lvl(port_h_pin_in));
  // clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s: %h not %h", $time, msg, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // write with address and data offered together, holds until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // reset values, then an unmapped place
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, 32'h0, "reset value");
      chk(32'(r), 32'(PRH_RESP_OKAY), "read resp");
    end
    wr(8'h14, 32'h1, r);
    chk(32'(r), 32'(PRH_RESP_SLVERR), "unmapped write");
    rd(8'h14, d, r);
    chk(32'(r), 32'(PRH_RESP_SLVERR), "unmapped read");
    $display("t_regs done");
  endtask
  // every two-bit code for channels 7 and 6, then single-bit channels
  task automatic t_route;
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  w;
    logic [7:0]  v, po;
    for (int c = 0; c < 4; c++) begin
      wr(PRH_OFF_ROUTE_HIGH, 32'hFFFF_FFFC | 32'(c), r);
      wr(PRH_OFF_ROUTE_LOW, 32'(c << 6), r);
      repeat (3) @(negedge aclk);
      w = {c == 0 || c == 3, c == 1, c == 2};
      chk(32'({port_p_pwm_en[7], port_s_pwm_en[1], port_v_pwm_en[3],
        port_p_pwm_out[7], port_s_pwm_out[1], port_v_pwm_out[3]}),
        32'({w, w}), "pwm7 route");
      chk(32'({port_p_pwm_en[6], port_s_pwm_en[0], port_v_pwm_en[2]}),
        32'(w), "pwm6 route");
      rd(PRH_OFF_ROUTE_HIGH, d, r);
      chk(d, 32'(c), "route high");
    end
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h2A : 8'h15;
      po = i ? 8'h5C : 8'hA3;
      @(posedge aclk);
      pwm_out <= po;
      wr(PRH_OFF_ROUTE_LOW, 32'(v), r);
      repeat (3) @(negedge aclk);
      chk(32'({port_p_pwm_en[5:0], port_v_pwm_en[1:0], port_s_pwm_en[7:4]}),
        32'({~v[5:0], v[5:4], v[3:0]}), "low route en");
      chk(32'({port_p_pwm_out[5:0], port_v_pwm_out[1:0],
        port_s_pwm_out[7:4]}), 32'({~v[5:0] & po[5:0], v[5:4] & po[5:4],
        v[3:0] & po[3:0]}), "low route out");
      rd(PRH_OFF_ROUTE_LOW, d, r);
      chk(d, 32'(v), "route low");
    end
    $display("t_route done");
  endtask
  // data read mux, input register and ignored input writes
  task automatic t_port;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    board_lvl <= 8'h3C;
    wr(PRH_OFF_H_DIR, 32'h0F, r);
    wr(PRH_OFF_H_DATA, 32'hA5, r);
    repeat (8) @(negedge aclk); // three-stage sync plus filter
    rd(PRH_OFF_H_DATA, d, r);
    chk(d, 32'h35, "data read");
    wr(PRH_OFF_H_INPUT, 32'hFF, r);
    chk(32'(r), 32'(PRH_RESP_OKAY), "input write");
    rd(PRH_OFF_H_INPUT, d, r);
    chk(d, 32'h35, "input read");
    @(negedge aclk);
    chk(32'(port_h_sync_in), 32'h35, "sync out");
    @(posedge aclk);
    s_axi_wstrb <= 4'hE;
    wr(PRH_OFF_H_DATA, 32'hFF, r);
    s_axi_wstrb <= 4'hF;
    rd(PRH_OFF_H_DATA, d, r);
    chk(d, 32'h35, "lane 0 off");
    $display("t_port done");
  endtask
  // expected pad drive from the function enables and drive levels
  function automatic logic [15:0] pin_ref(input logic [7:0] dir,
                                          input logic [7:0] dat);
    logic [7:0] oe;
    logic [7:0] o;
    oe = dir;
    o = dat;
    if (bus_clock_output_en) begin
      oe[2] = 1'b1;
      o[2] = drv[12];
    end
    if (spi_en) begin
      {o[3], oe[3]} = drv[5:4];
      {o[2], oe[2]} = drv[7:6];
      {o[1], oe[1]} = drv[9:8];
      {o[0], oe[0]} = drv[11:10];
    end
    if (iic_en) begin
      {o[3], oe[3]} = drv[1:0];
      {o[0], oe[0]} = drv[3:2];
    end
    oe = oe & ~lcd_seg_en;
    return {oe, o & oe};
  endfunction
  // all mixes of lcd, iic, spi and bus clock output
  task automatic t_prio;
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] s, e;
    wr(PRH_OFF_H_DIR, 32'hFF, r);
    rd(PRH_OFF_H_DATA, d, r);
    chk(d, 32'hA5, "data reg read");
    for (int k = 0; k < 16; k++) begin
      @(posedge aclk);
      lcd_seg_en <= k[3] ? 8'h5A : 8'h00;
      {iic_en, spi_en, bus_clock_output_en} <= k[2:0];
      drv <= 13'(k * 32'h397) ^ 13'h0B6D;
      repeat (2) @(negedge aclk);
      e = pin_ref(8'hFF, 8'hA5);
      s = {port_h_pin_oe, port_h_pin_out & port_h_pin_oe};
      chk(32'(s[15:8]), 32'(e[15:8]), "pin oe");
      chk(32'(s[7:0]), 32'(e[7:0]), "pin out");
    end
    $display("t_prio done");
  endtask
  // watchdog
  initial begin
    #(50 * 6000);
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, iic_en, spi_en} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {bus_clock_output_en, drv, lcd_seg_en, board_lvl} = 30'h0;
    s_axi_wstrb = 4'hF;
    pwm_out = 8'hC5;
    pwm_en = 8'hFF;
    err_count = 0;
    n_compared = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_route();
    t_port();
    t_prio();
    end_of_test();
  end
endmodule
`default_nettype wire
